/* File: rtl/core_ctrl.sv */
`timescale 1ns/100ps
module core_ctrl
  import core_ctrl_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LAST_SRAM_ADDR = 16'h08FF,
  parameter logic [15:0] BOOT_START = 16'h3800,
  parameter logic [NUM_IRQ-1:0] LEVEL_MASK = 8'h00
) (
  input wire logic clk_in, // core clock, undivided
  input wire logic arst_n_in, // async reset, active low
  input wire logic reloc_fuse_in, // reset vector relocation strap
  input wire logic sleeping_in, // core is asleep
  input wire logic step_in, // one instruction completes
  input wire rf_req_t rf_req_in, // register file access
  input wire ptr_req_t ptr_req_in, // pointer data-space access
  input wire stack_op_t stack_op_in, // stack op with this step
  input wire logic [7:0] push_data_in, // byte to push
  input wire logic [15:0] ret_addr_in, // return address to push
  input wire logic [7:0] mem_rdata_in, // byte read at data space
  input wire logic io_wr_in, // io write strobe
  input wire logic io_rd_in, // io read strobe
  input wire logic [5:0] io_addr_in, // io offset
  input wire logic [7:0] io_wdata_in, // io write data
  input wire logic [NUM_IRQ-1:0] irq_event_in, // flag source events (pins)
  input wire logic [NUM_IRQ-1:0] irq_level_in, // level source conditions
  output logic [7:0] io_rdata_out, // io read data
  output logic [15:0] rd_a_out, // operand a (16 bit with rd_a_16)
  output logic [7:0] rd_b_out, // operand b
  output logic [7:0] status_out, // status flags
  output logic [ADDR_W-1:0] sp_out, // stack pointer
  output logic mem_we_out, // data space write strobe
  output logic mem_re_out, // data space read strobe
  output logic [ADDR_W-1:0] mem_addr_out, // data space address
  output logic [7:0] mem_wdata_out, // data space write byte
  output logic [7:0] pop_data_out, // popped byte / register read
  output logic [15:0] pc_load_out, // new program counter
  output logic pc_load_en_out, // pulse: load program counter
  output logic busy_out // stall execution stream
);
  typedef enum {ST_RUN, ST_ENTRY, ST_RETURN} seq_t;

  logic [7:0] regs_ff [NUM_REGS];
  logic [7:0] status_ff;
  logic [ADDR_W-1:0] sp_ff;
  logic [NUM_IRQ-1:0] flag_ff, enable_ff, ev_s1_ff, ev_s2_ff, ev_d_ff, lv_s1_ff, lv_s2_ff;
  logic [7:0] proc_ctrl_ff;
  logic reloc_ff, strap_taken_ff, boot_ff;
  seq_t state_ff;
  logic [2:0] cnt_ff;
  logic hold_ff;
  logic [$clog2(NUM_IRQ)-1:0] win_ff;
  logic [7:0] ret_lo_ff, ret_hi_ff;
  logic [NUM_IRQ-1:0] ev_rise, pending;
  logic take_any;
  logic [$clog2(NUM_IRQ)-1:0] take_idx;
  logic [ADDR_W-1:0] ptr_base, ptr_addr;
  logic [4:0] ptr_lo_idx;
  logic io_st_wr, gie_now, take;

  function automatic logic [4:0] ptr_index(input logic [1:0] sel);
    unique case (sel)
      2'd0: ptr_index = PTR_X_LO;
      2'd1: ptr_index = PTR_Y_LO;
      default: ptr_index = PTR_Z_LO;
    endcase
  endfunction : ptr_index

  // pins cross in through two flops before anything looks at them
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ev_s1_ff <= '0;
      ev_s2_ff <= '0;
      ev_d_ff <= '0;
      lv_s1_ff <= '0;
      lv_s2_ff <= '0;
    end else begin
      ev_s1_ff <= irq_event_in;
      ev_s2_ff <= ev_s1_ff;
      ev_d_ff <= ev_s2_ff;
      lv_s1_ff <= irq_level_in;
      lv_s2_ff <= lv_s1_ff;
    end
  end

  assign ev_rise = ev_s2_ff & ~ev_d_ff;
  assign ptr_lo_idx = ptr_index(ptr_req_in.ptr_sel);
  assign ptr_base = {regs_ff[ptr_lo_idx + 5'd1], regs_ff[ptr_lo_idx]};
  always_comb begin
    unique case (ptr_req_in.mode)
      PTR_PRE_DEC: ptr_addr = ptr_base - SP_STEP_BYTE;
      PTR_DISP: ptr_addr = ptr_base + {10'h000, ptr_req_in.disp};
      PTR_PLAIN, PTR_POST_INC: ptr_addr = ptr_base;
    endcase
  end

  // flag sources latch while disabled; level sources request only while present
  assign pending = (flag_ff & ~LEVEL_MASK | lv_s2_ff & LEVEL_MASK) & enable_ff;
  assign io_st_wr = io_wr_in && io_addr_in == IO_STATUS;
  // a disable in this step blocks any take in the same cycle
  assign gie_now = status_ff[FLAG_I] && stack_op_in != OP_CLI
    && !(io_st_wr && !io_wdata_in[FLAG_I]);
  assign take = state_ff == ST_RUN && step_in && take_any && gie_now && !hold_ff
    && stack_op_in == OP_NONE && !rf_req_in.wr_en;

  irq_arbiter #(.N(NUM_IRQ)) u_arb (
    .req_in(pending),
    .any_out(take_any),
    .idx_out(take_idx)
  );

  // reset vector placement strap caught once after release
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_taken_ff <= 1'b0;
      boot_ff <= 1'b0;
    end else if (!strap_taken_ff) begin
      strap_taken_ff <= 1'b1;
      boot_ff <= reloc_fuse_in;
    end
  end

  // register file; sets from the step win over pointer post-increment on same reg
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= 8'h00;
      end
    end else if (!busy_out) begin
      if (ptr_req_in.valid && (ptr_req_in.mode == PTR_POST_INC || ptr_req_in.mode == PTR_PRE_DEC)) begin
        {regs_ff[ptr_lo_idx + 5'd1], regs_ff[ptr_lo_idx]} <= ptr_req_in.mode == PTR_POST_INC
          ? ptr_base + SP_STEP_BYTE : ptr_addr;
      end
      if (ptr_req_in.valid && ptr_req_in.wr && ptr_addr < REG_SPACE_END) begin
        regs_ff[ptr_addr[4:0]] <= ptr_req_in.wdata;
      end
      if (rf_req_in.wr_en) begin
        regs_ff[rf_req_in.wr_addr] <= rf_req_in.wr_data[7:0];
        if (rf_req_in.wr_16) begin
          regs_ff[rf_req_in.wr_addr + 5'd1] <= rf_req_in.wr_data[15:8];
        end
      end
    end
  end

  // status flags; never saved or restored around handlers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_ff <= STATUS_RESET;
    end else if (io_st_wr) begin
      status_ff <= io_wdata_in;
    end else if (take) begin
      status_ff[FLAG_I] <= 1'b0;
    end else if (state_ff == ST_RETURN && cnt_ff == RETURN_CYCLES - 3'd1) begin
      status_ff[FLAG_I] <= 1'b1;
    end else if (state_ff == ST_RUN && step_in) begin
      if (rf_req_in.flag_upd) begin
        status_ff[FLAG_N] <= rf_req_in.flags_nzc[2];
        status_ff[FLAG_Z] <= rf_req_in.flags_nzc[1];
        status_ff[FLAG_C] <= rf_req_in.flags_nzc[0];
      end
      if (stack_op_in == OP_SEI) begin
        status_ff[FLAG_I] <= 1'b1;
      end else if (stack_op_in == OP_CLI) begin
        status_ff[FLAG_I] <= 1'b0;
      end
    end
  end

  // one more instruction after enable or return before any take
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_ff <= 1'b0;
    end else if (state_ff == ST_RETURN) begin
      hold_ff <= 1'b1;
    end else if (state_ff == ST_RUN && step_in) begin
      hold_ff <= stack_op_in == OP_SEI || (io_st_wr && io_wdata_in[FLAG_I] && !status_ff[FLAG_I]);
    end
  end

  // interrupt flags: set beats clear, write one clears
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        if (ev_rise[i]) begin
          flag_ff[i] <= 1'b1;
        end else if (io_wr_in && io_addr_in == IO_IRQ_FLAGS && io_wdata_in[i]) begin
          flag_ff[i] <= 1'b0;
        end else if (take && take_idx == i[$clog2(NUM_IRQ)-1:0]) begin
          flag_ff[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      enable_ff <= '0;
      proc_ctrl_ff <= 8'h00;
    end else if (io_wr_in) begin
      if (io_addr_in == IO_IRQ_ENABLE) enable_ff <= io_wdata_in[NUM_IRQ-1:0];
      if (io_addr_in == IO_PROC_CTRL) proc_ctrl_ff <= io_wdata_in;
    end
  end
  assign reloc_ff = proc_ctrl_ff[RELOC_BIT];

  // entry and return sequencers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= ST_RUN;
      cnt_ff <= '0;
      win_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_RUN: begin
          cnt_ff <= '0;
          if (take) begin
            state_ff <= ST_ENTRY;
            win_ff <= take_idx;
            cnt_ff <= sleeping_in ? 3'd0 - SLEEP_EXTRA : 3'd0;
          end else if (step_in && stack_op_in == OP_RETURN_FROM_INTERRUPT) begin
            state_ff <= ST_RETURN;
          end
        end
        ST_ENTRY: begin
          cnt_ff <= cnt_ff + 3'd1;
          if (cnt_ff == ENTRY_CYCLES - 3'd1) state_ff <= ST_RUN;
        end
        ST_RETURN: begin
          cnt_ff <= cnt_ff + 3'd1;
          if (cnt_ff == RETURN_CYCLES - 3'd1) state_ff <= ST_RUN;
        end
      endcase
    end
  end

  // stack pointer and its data space traffic
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sp_ff <= LAST_SRAM_ADDR;
      mem_we_out <= 1'b0;
      mem_re_out <= 1'b0;
      mem_addr_out <= '0;
      mem_wdata_out <= 8'h00;
      pc_load_en_out <= 1'b0;
      pc_load_out <= 16'h0000;
      ret_lo_ff <= 8'h00;
      ret_hi_ff <= 8'h00;
    end else begin
      mem_we_out <= 1'b0;
      mem_re_out <= 1'b0;
      pc_load_en_out <= 1'b0;
      if (io_wr_in && io_addr_in == IO_SP_LOW) sp_ff[7:0] <= io_wdata_in;
      if (io_wr_in && io_addr_in == IO_SP_HIGH) sp_ff[15:8] <= io_wdata_in;
      if (state_ff == ST_ENTRY && cnt_ff < 3'd2 && cnt_ff[2] == 1'b0) begin
        mem_we_out <= 1'b1;
        mem_addr_out <= sp_ff;
        mem_wdata_out <= cnt_ff[0] ? ret_addr_in[15:8] : ret_addr_in[7:0];
        sp_ff <= sp_ff - SP_STEP_BYTE;
      end else if (state_ff == ST_ENTRY && cnt_ff == ENTRY_CYCLES - 3'd1) begin
        pc_load_en_out <= 1'b1;
        pc_load_out <= (reloc_ff ? BOOT_START : 16'h0000) + VEC_FIRST_IRQ
          + 16'(win_ff) * VEC_STEP;
      end else if (state_ff == ST_RETURN && cnt_ff < 3'd2) begin
        mem_re_out <= 1'b1;
        mem_addr_out <= sp_ff + SP_STEP_BYTE;
        sp_ff <= sp_ff + SP_STEP_BYTE;
        if (cnt_ff == 3'd1) begin
          ret_hi_ff <= mem_rdata_in; // high byte sits lower, so it pops first
        end
      end else if (state_ff == ST_RETURN && cnt_ff == 3'd2) begin
        ret_lo_ff <= mem_rdata_in;
      end else if (state_ff == ST_RETURN && cnt_ff == RETURN_CYCLES - 3'd1) begin
        pc_load_en_out <= 1'b1;
        pc_load_out <= {ret_hi_ff, ret_lo_ff};
      end else if (state_ff == ST_RUN && step_in && !take) begin
        unique case (stack_op_in)
          OP_PUSH: begin
            mem_we_out <= 1'b1;
            mem_addr_out <= sp_ff;
            mem_wdata_out <= push_data_in;
            sp_ff <= sp_ff - SP_STEP_BYTE;
          end
          OP_POP: begin
            mem_re_out <= 1'b1;
            mem_addr_out <= sp_ff + SP_STEP_BYTE;
            sp_ff <= sp_ff + SP_STEP_BYTE;
          end
          OP_CALL: begin
            mem_we_out <= 1'b1;
            mem_addr_out <= sp_ff;
            mem_wdata_out <= ret_addr_in[7:0];
            sp_ff <= sp_ff - SP_STEP_ADDR;
          end
          OP_RET: begin
            mem_re_out <= 1'b1;
            mem_addr_out <= sp_ff + SP_STEP_BYTE;
            sp_ff <= sp_ff + SP_STEP_ADDR;
          end
          default: begin
            if (ptr_req_in.valid && ptr_addr >= REG_SPACE_END) begin
              mem_we_out <= ptr_req_in.wr;
              mem_re_out <= !ptr_req_in.wr;
              mem_addr_out <= ptr_addr;
              mem_wdata_out <= ptr_req_in.wdata;
            end
          end
        endcase
      end
    end
  end

  // read side: io read data, operands, popped byte
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      io_rdata_out <= 8'h00;
      rd_a_out <= 16'h0000;
      rd_b_out <= 8'h00;
      pop_data_out <= 8'h00;
      status_out <= STATUS_RESET;
      sp_out <= LAST_SRAM_ADDR;
      busy_out <= 1'b0;
    end else begin
      status_out <= status_ff;
      sp_out <= sp_ff;
      // stall starts with the return step itself, not a cycle later
      busy_out <= take || (state_ff == ST_RUN && step_in && stack_op_in == OP_RETURN_FROM_INTERRUPT)
        || (state_ff != ST_RUN && !(state_ff == ST_ENTRY && cnt_ff == ENTRY_CYCLES - 3'd1)
        && !(state_ff == ST_RETURN && cnt_ff == RETURN_CYCLES - 3'd1));
      rd_a_out <= rf_req_in.rd_a_16 ? {regs_ff[rf_req_in.rd_a + 5'd1], regs_ff[rf_req_in.rd_a]}
        : {8'h00, regs_ff[rf_req_in.rd_a]};
      rd_b_out <= regs_ff[rf_req_in.rd_b];
      pop_data_out <= (ptr_req_in.valid && ptr_addr < REG_SPACE_END) ? regs_ff[ptr_addr[4:0]]
        : mem_rdata_in;
      if (io_rd_in) begin
        unique case (io_addr_in)
          IO_SP_LOW: io_rdata_out <= sp_ff[7:0];
          IO_SP_HIGH: io_rdata_out <= sp_ff[15:8];
          IO_STATUS: io_rdata_out <= status_ff;
          IO_PROC_CTRL: io_rdata_out <= {proc_ctrl_ff[7:1], boot_ff};
          IO_IRQ_FLAGS: io_rdata_out <= flag_ff;
          IO_IRQ_ENABLE: io_rdata_out <= enable_ff;
          default: io_rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule : core_ctrl

/* File: common/core_ctrl_pkg.sv */
package core_ctrl_pkg;
  localparam int NUM_REGS = 32;
  localparam int ADDR_W = 16;
  localparam int NUM_IRQ = 8;
  localparam logic [5:0] IO_SP_LOW = 6'h3D;
  localparam logic [5:0] IO_SP_HIGH = 6'h3E;
  localparam logic [5:0] IO_STATUS = 6'h3F;
  localparam logic [5:0] IO_PROC_CTRL = 6'h35;
  localparam logic [5:0] IO_IRQ_FLAGS = 6'h20;
  localparam logic [5:0] IO_IRQ_ENABLE = 6'h21;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 7;
  localparam int RELOC_BIT = 1;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [ADDR_W-1:0] REG_SPACE_END = 16'h0020;
  localparam logic [ADDR_W-1:0] SP_STEP_BYTE = 16'h0001;
  localparam logic [ADDR_W-1:0] SP_STEP_ADDR = 16'h0002;
  localparam logic [2:0] ENTRY_CYCLES = 3'h4;
  localparam logic [2:0] SLEEP_EXTRA = 3'h4;
  localparam logic [2:0] RETURN_CYCLES = 3'h4;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [15:0] VEC_FIRST_IRQ = 16'h0002;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_RETURN_FROM_INTERRUPT, OP_SEI, OP_CLI
  } stack_op_t;

  typedef enum logic [1:0] {
    PTR_PLAIN, PTR_POST_INC, PTR_PRE_DEC, PTR_DISP
  } ptr_mode_t;

  // one instruction-step request from the execution stream
  typedef struct packed {
    logic rd_a_16;
    logic [4:0] rd_a;
    logic [4:0] rd_b;
    logic wr_en;
    logic wr_16;
    logic [4:0] wr_addr;
    logic [15:0] wr_data;
    logic flag_upd;
    logic [2:0] flags_nzc;
  } rf_req_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [1:0] ptr_sel;
    ptr_mode_t mode;
    logic [5:0] disp;
    logic [7:0] wdata;
  } ptr_req_t;
endpackage : core_ctrl_pkg

/* File: rtl/irq_arbiter.sv */
`timescale 1ns/100ps
module irq_arbiter
  import core_ctrl_pkg::*;
#(
  parameter int N = NUM_IRQ
) (
  input wire logic [N-1:0] req_in, // enabled requests
  output logic any_out, // some request present
  output logic [$clog2(N)-1:0] idx_out // winning index
);
  // lowest index means lowest vector address, so it wins
  always_comb begin
    any_out = 1'b0;
    idx_out = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        any_out = 1'b1;
        idx_out = i[$clog2(N)-1:0];
      end
    end
  end
endmodule : irq_arbiter

/* File: dv/core_ctrl_chk.sv */
`timescale 1ns/100ps
module core_ctrl_chk
  import core_ctrl_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LAST_SRAM_ADDR = 16'h08FF
) (
  input wire logic clk_in, // core clock
  input wire logic arst_n_in, // reset, low
  input wire logic sleeping_in, // asleep
  input wire logic step_in, // step done
  input wire rf_req_t rf_req_in, // reg request
  input wire stack_op_t stack_op_in, // stack op
  input wire logic [7:0] push_data_in, // push byte
  input wire logic [15:0] ret_addr_in, // return pc
  input wire logic io_wr_in, // io write
  input wire logic io_rd_in, // io read
  input wire logic [5:0] io_addr_in, // io offset
  input wire logic [7:0] io_rdata_out, // io data
  input wire logic [7:0] status_out, // status
  input wire logic [ADDR_W-1:0] sp_out, // stack ptr
  input wire logic mem_we_out, // data write
  input wire logic [7:0] mem_wdata_out, // data byte
  input wire logic pc_load_en_out, // pc load
  input wire logic busy_out // stall
);
  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  logic go;
  assign go = step_in && !busy_out;

  AST_RESET_SP: assert property ($rose(arst_n_in) |-> sp_out == LAST_SRAM_ADDR)
    else $error("sp wrong after reset");
  AST_PUSH_WR: assert property (go && stack_op_in == OP_PUSH |=> mem_we_out && mem_wdata_out == $past(push_data_in))
    else $error("push byte not written");
  AST_CALL_WR: assert property (go && stack_op_in == OP_CALL |=> mem_we_out && mem_wdata_out == $past(ret_addr_in[7:0]))
    else $error("call low byte not written");
  AST_RETURN_FROM_INTERRUPT_SEQ: assert property (go && stack_op_in == OP_RETURN_FROM_INTERRUPT |=> busy_out [*4] ##1 pc_load_en_out)
    else $error("return sequence length wrong");
  AST_ENTRY_SEQ: assert property ($rose(busy_out) && !$past(go && stack_op_in == OP_RETURN_FROM_INTERRUPT) && !$past(sleeping_in)
    |-> busy_out [*4] ##1 pc_load_en_out)
    else $error("entry length wrong");
  AST_SLEEP_ENTRY: assert property ($rose(busy_out) && !$past(go && stack_op_in == OP_RETURN_FROM_INTERRUPT) && $past(sleeping_in)
    |-> busy_out [*8] ##1 pc_load_en_out)
    else $error("entry from sleep length wrong");
  AST_ENTRY_WR: assert property ($rose(busy_out) && !$past(go && stack_op_in == OP_RETURN_FROM_INTERRUPT) && !$past(sleeping_in)
    |=> mem_we_out && mem_wdata_out == $past(ret_addr_in[7:0]))
    else $error("entry did not push pc");
  AST_CLI_BLOCK: assert property (go && stack_op_in == OP_CLI |=> !pc_load_en_out [*4])
    else $error("vector taken after disable");
  AST_FLAGS: assert property (go && rf_req_in.flag_upd ##1 !(step_in && rf_req_in.flag_upd)
    |=> status_out[2:0] == $past(rf_req_in.flags_nzc, 2))
    else $error("result flags wrong");
  // quiet window only: sp_out trails the live pointer
  AST_SP_READ: assert property (io_rd_in && io_addr_in == IO_SP_LOW && !io_wr_in && !$past(io_wr_in) && !busy_out
    && !$past(busy_out) && !step_in && !$past(step_in) |=> io_rdata_out == $past(sp_out[7:0]))
    else $error("sp low read wrong");
endmodule : core_ctrl_chk

bind core_ctrl core_ctrl_chk #(.LAST_SRAM_ADDR(LAST_SRAM_ADDR)) core_ctrl_chk_i (.clk_in, .arst_n_in, .sleeping_in,
  .step_in, .rf_req_in, .stack_op_in, .push_data_in, .ret_addr_in, .io_wr_in, .io_rd_in, .io_addr_in, .io_rdata_out,
  .status_out, .sp_out, .mem_we_out, .mem_wdata_out, .pc_load_en_out, .busy_out);

/* File: dv/mem_partner.sv */
`timescale 1ns/100ps
module mem_partner (
  input wire logic clk_in, // core clock
  input wire logic we_in, // write strobe
  input wire logic re_in, // read strobe
  input wire logic [15:0] addr_in, // address
  input wire logic [7:0] wdata_in, // write byte
  output logic [7:0] rdata_out // read byte
);
  logic [7:0] mem [0:255];
  logic [7:0] last_ff;
  initial begin
    last_ff = 8'h3C;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'hE7;
    end
  end
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in[7:0]] <= wdata_in;
    end
    if (re_in) begin
      last_ff <= mem[addr_in[7:0]];
    end
  end
  // idle bus shows inverted last byte so stale data cannot pass
  assign rdata_out = re_in ? mem[addr_in[7:0]] : ~last_ff;
endmodule : mem_partner

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import core_ctrl_pkg::*;
  localparam logic [15:0] BOOT = 16'h3800;
  localparam logic [15:0] RET_PC = 16'hBEEF;
  logic clk_in, arst_n_in, step_in, io_wr_in, io_rd_in, sleeping_in;
  logic mem_we_out, mem_re_out, pc_load_en_out, busy_out;
  rf_req_t rf_req_in;
  ptr_req_t ptr_req_in;
  stack_op_t stack_op_in;
  logic [7:0] push_data_in, mem_rdata_in, io_wdata_in, io_rdata_out;
  logic [7:0] rd_b_out, status_out, mem_wdata_out, pop_data_out;
  logic [5:0] io_addr_in;
  logic [NUM_IRQ-1:0] irq_event_in, irq_level_in;
  logic [15:0] rd_a_out, sp_out, mem_addr_out, pc_load_out, pc;
  int err_count, samples_checked;

  core_ctrl #(.BOOT_START(BOOT), .LEVEL_MASK(8'h80)) core_ctrl_i (.clk_in, .arst_n_in, .reloc_fuse_in(1'b0), .sleeping_in,
    .step_in, .rf_req_in, .ptr_req_in, .stack_op_in, .push_data_in, .ret_addr_in(RET_PC), .mem_rdata_in,
    .io_wr_in, .io_rd_in, .io_addr_in, .io_wdata_in, .irq_event_in, .irq_level_in, .io_rdata_out,
    .rd_a_out, .rd_b_out, .status_out, .sp_out, .mem_we_out, .mem_re_out, .mem_addr_out, .mem_wdata_out,
    .pop_data_out, .pc_load_out, .pc_load_en_out, .busy_out);
  mem_partner mem_partner_i (.clk_in, .we_in(mem_we_out), .re_in(mem_re_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task stop_test();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task io_wr(input logic [5:0] a, input logic [7:0] d);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    tick(1);
    io_wr_in = 1'b0;
  endtask : io_wr

  task io_chk(input logic [5:0] a, input logic [7:0] e);
    io_addr_in = a;
    io_rd_in = 1'b1;
    tick(1);
    io_rd_in = 1'b0;
    tick(1);
    chk({8'h00, io_rdata_out}, {8'h00, e});
  endtask : io_chk

  task sp_chk(input logic [15:0] e);
    io_chk(IO_SP_HIGH, e[15:8]);
    io_chk(IO_SP_LOW, e[7:0]);
  endtask : sp_chk

  task busy_chk(input logic e);
    chk({15'h0000, busy_out}, {15'h0000, e});
  endtask : busy_chk

  // pointer request lasts exactly the one step so auto-increment fires once
  task step(input stack_op_t op, input logic [7:0] d);
    stack_op_in = op;
    push_data_in = d;
    step_in = 1'b1;
    tick(1);
    step_in = 1'b0;
    stack_op_in = OP_NONE;
    ptr_req_in = '0;
    tick(1);
  endtask : step

  task wait_pc(output logic [15:0] v);
    int i;
    v = 16'h0000;
    for (i = 0; i < 16; i++) begin
      if (pc_load_en_out === 1'b1) begin
        v = pc_load_out;
        break;
      end
      tick(1);
    end
    if (i == 16) begin
      err_count++;
      stop_test();
    end
    tick(2);
  endtask : wait_pc

  task pulse(input logic [7:0] m);
    irq_event_in = m;
    tick(4);
    irq_event_in = 8'h00;
    tick(4);
  endtask : pulse

  initial begin
    {step_in, io_wr_in, io_rd_in, arst_n_in} = 4'h0;
    io_addr_in = 6'h00;
    io_wdata_in = 8'h00;
    rf_req_in = '0;
    ptr_req_in = '0;
    stack_op_in = OP_NONE;
    push_data_in = 8'h00;
    irq_level_in = 8'h00;
    sleeping_in = 1'b0;
    irq_event_in = 8'h00;
    err_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    tick(2);
    sp_chk(16'h08FF);
    io_chk(IO_STATUS, STATUS_RESET);
    io_wr(IO_SP_HIGH, 8'h08);
    io_wr(IO_SP_LOW, 8'h80);
    sp_chk(16'h0880);
    step(OP_PUSH, 8'hA5);
    sp_chk(16'h087F);
    chk({8'h00, mem_partner_i.mem[8'h80]}, 16'h00A5);
    step(OP_POP, 8'h00);
    chk({8'h00, pop_data_out}, 16'h00A5);
    sp_chk(16'h0880);
    step(OP_CALL, 8'h00);
    sp_chk(16'h087E);
    step(OP_RET, 8'h00);
    sp_chk(16'h0880);
    rf_req_in.wr_en = 1'b1;
    rf_req_in.wr_addr = 5'h01;
    rf_req_in.wr_data = 16'h0033;
    rf_req_in.flag_upd = 1'b1;
    rf_req_in.flags_nzc = 3'b101;
    step(OP_NONE, 8'h00);
    rf_req_in.wr_16 = 1'b1;
    rf_req_in.wr_addr = PTR_X_LO;
    rf_req_in.wr_data = 16'h0001;
    rf_req_in.flag_upd = 1'b0;
    rf_req_in.rd_b = 5'h01;
    step(OP_NONE, 8'h00);
    chk({8'h00, rd_b_out}, 16'h0033);
    rf_req_in = '0;
    rf_req_in.rd_a_16 = 1'b1;
    rf_req_in.rd_a = PTR_X_LO;
    ptr_req_in.valid = 1'b1;
    tick(1);
    chk(rd_a_out, 16'h0001);
    chk({8'h00, pop_data_out}, 16'h0033);
    ptr_req_in.valid = 1'b1;
    ptr_req_in.mode = PTR_POST_INC;
    step(OP_NONE, 8'h00);
    tick(2);
    chk(rd_a_out, 16'h0002);
    rf_req_in = '0;
    io_chk(IO_STATUS, 8'h05);
    io_wr(IO_IRQ_ENABLE, 8'h06);
    pulse(8'h06);
    busy_chk(1'b0);
    io_chk(IO_IRQ_FLAGS, 8'h06);
    step(OP_SEI, 8'h00);
    step(OP_NONE, 8'h00);
    busy_chk(1'b0);
    step(OP_NONE, 8'h00);
    busy_chk(1'b1);
    wait_pc(pc);
    chk(pc, VEC_FIRST_IRQ + VEC_STEP);
    io_chk(IO_IRQ_FLAGS, 8'h04);
    io_chk(IO_STATUS, 8'h05);
    sp_chk(16'h087E);
    step(OP_RETURN_FROM_INTERRUPT, 8'h00);
    wait_pc(pc);
    chk(pc, RET_PC);
    io_chk(IO_STATUS, 8'h85);
    sp_chk(16'h0880);
    step(OP_NONE, 8'h00);
    busy_chk(1'b0);
    step(OP_NONE, 8'h00);
    wait_pc(pc);
    chk(pc, VEC_FIRST_IRQ + VEC_STEP + VEC_STEP);
    pulse(8'h08);
    io_chk(IO_IRQ_FLAGS, 8'h08);
    io_wr(IO_IRQ_FLAGS, 8'hF7);
    io_chk(IO_IRQ_FLAGS, 8'h08);
    io_wr(IO_IRQ_FLAGS, 8'h08);
    io_chk(IO_IRQ_FLAGS, 8'h00);
    io_wr(IO_PROC_CTRL, 8'h02);
    io_wr(IO_IRQ_ENABLE, 8'h01);
    pulse(8'h01);
    step(OP_SEI, 8'h00);
    step(OP_NONE, 8'h00);
    step(OP_CLI, 8'h00);
    busy_chk(1'b0);
    step(OP_NONE, 8'h00);
    busy_chk(1'b0);
    step(OP_SEI, 8'h00);
    step(OP_NONE, 8'h00);
    step(OP_NONE, 8'h00);
    wait_pc(pc);
    chk(pc, BOOT + VEC_FIRST_IRQ);
    irq_level_in = 8'h80;
    tick(4);
    irq_level_in = 8'h00;
    tick(4);
    io_wr(IO_IRQ_ENABLE, 8'h80);
    step(OP_SEI, 8'h00);
    step(OP_NONE, 8'h00);
    step(OP_NONE, 8'h00);
    busy_chk(1'b0);
    irq_level_in = 8'h80;
    sleeping_in = 1'b1;
    tick(4);
    step(OP_NONE, 8'h00);
    tick(4);
    busy_chk(1'b1);
    sleeping_in = 1'b0;
    wait_pc(pc);
    chk(pc, BOOT + VEC_FIRST_IRQ + VEC_STEP * 16'h0007);
    stop_test();
  end
endmodule : testbench
